/* File: verilog/asprf_defines.vh */
// Shared constants for the converter serial port block.
`ifndef ASPRF_DEFINES_VH
`define ASPRF_DEFINES_VH
`define ASPRF_COMM_WR_BIT      7
`define ASPRF_COMM_RSEL_HI     3
`define ASPRF_COMM_RSEL_LO     0
`define ASPRF_REG_COMM         4'h0
`define ASPRF_REG_STATUS       4'h0
`define ASPRF_REG_MODE         4'h1
`define ASPRF_REG_CTRL         4'h2
`define ASPRF_REG_FILTER       4'h3
`define ASPRF_REG_DATA         4'h4
`define ASPRF_REG_OFFSET       4'h5
`define ASPRF_REG_GAIN         4'h6
`define ASPRF_MODE_BITS_HI     2
`define ASPRF_MODE_CAL_MIN     3'h4
`define ASPRF_RST_MODE         8'h00
`define ASPRF_RST_CTRL         8'h07
`define ASPRF_RST_FILTER       8'h45
`define ASPRF_RST_OFFSET       24'h800000
`define ASPRF_RST_GAIN         24'h500000
`define ASPRF_FIFO_DEPTH       8
`endif

/* File: verilog/asprf_fifo.v */
// Parameterised valid/ready FIFO for conversion results.
module asprf_fifo #(
    parameter WIDTH = 24,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset.
    input  wire             i_clk,
    input  wire             i_resetn,
    // Fill side.
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // Drain side.
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_reg;
    reg [AW-1:0]    rd_reg;
    reg [AW:0]      cnt_reg;
    reg             room_reg;
    wire            push;
    wire            pop;

    assign o_in_ready  = room_reg;
    assign o_out_valid = (cnt_reg != {(AW+1){1'b0}});
    assign o_out_data  = mem_reg[rd_reg];
    assign push        = i_in_valid & o_in_ready;
    assign pop         = o_out_valid & i_out_ready;

    always @(posedge i_clk) begin
        if (push) begin
            mem_reg[wr_reg] <= i_in_data;
        end
    end

    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_reg  <= {AW{1'b0}};
            rd_reg  <= {AW{1'b0}};
            cnt_reg <= {(AW+1){1'b0}};
            room_reg <= 1'b1;
        end else begin
            if (push) begin
                wr_reg <= (wr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_reg + 1'b1;
            end
            // Room is kept in a flop so the fill side sees a registered ready.
            if (push && !pop) begin
                cnt_reg  <= cnt_reg + 1'b1;
                room_reg <= (cnt_reg != DEPTH[AW:0] - 1'b1);
            end else if (pop && !push) begin
                cnt_reg  <= cnt_reg - 1'b1;
                room_reg <= 1'b1;
            end
        end
    end
endmodule

/* File: verilog/asprf_serial_port.v */
// Serial port, register set and ready flag of the converter.
`include "asprf_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Serial port reacts only while select is low.
// - Select rising ends the frame; a new frame starts at the comms write.
// - With select tied low the port works as three-wire link.
// - Ready goes low while an unread result sits in the data register.
// - Ready returns high when a data register read completes.
// - Unread result: ready rises before the data register is updated.
// - Ready goes low when a calibration finishes.
// - After calibration ready stays low until mode bits are written.
// - Output shift register loads from any data, calibration or control reg.
// - Input shift word goes to the register chosen by comms select bits.
// - Gated or continuous serial clock both work; state kept between bursts.
// - Reset returns port and registers to their power-on state.
module asprf_serial_port #(
    parameter DW = 24
) (
    // Clock and reset.
    input  wire          i_clk,
    input  wire          i_resetn,
    // Serial pins.
    input  wire          i_cs_n,
    input  wire          i_sclk,
    input  wire          i_din,
    output reg           o_dout,
    output reg           o_rdy_n,
    // Converter core side.
    input  wire          i_conv_valid,
    output wire          o_conv_ready,
    input  wire [DW-1:0] i_conv_data,
    input  wire          i_cal_done,
    output reg  [7:0]    o_mode,
    output reg           o_mode_wr,
    output reg  [7:0]    o_ctrl,
    output reg  [7:0]    o_filter,
    output reg  [DW-1:0] o_offset,
    output reg  [DW-1:0] o_gain
);
    localparam ST_COMM = 2'h0;
    localparam ST_WR   = 2'h1;
    localparam ST_RD   = 2'h2;

    reg  [1:0]    cs_sync_reg;
    reg  [2:0]    sclk_sync_reg;
    reg  [1:0]    din_sync_reg;
    reg  [1:0]    state_reg;
    reg  [4:0]    bits_reg;
    reg  [DW-1:0] in_sh_reg;
    reg  [DW-1:0] out_sh_reg;
    reg  [3:0]    sel_reg;
    reg  [DW-1:0] data_reg;
    reg           unread_reg;
    reg           cal_hold_reg;
    reg  [4:0]    len_next;
    reg  [DW-1:0] rd_word;
    wire          sel_active;
    wire          rise;
    wire          fall;
    wire          fifo_valid;
    wire [DW-1:0] fifo_data;
    wire          take;
    wire [DW-1:0] in_word;

    // Only the later stages are read; the first stage of each synchroniser stays private.
    assign sel_active = ~cs_sync_reg[1];
    assign rise       = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign fall       = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign in_word    = {in_sh_reg[DW-2:0], din_sync_reg[1]};
    // A fresh result is taken only when the data register is idle on the link.
    // Waiting for ready to stand high first means a host never sees it low
    // on a word that is then replaced under it.
    assign take       = fifo_valid & o_rdy_n &
                        ~(state_reg == ST_RD && sel_reg == `ASPRF_REG_DATA);

    asprf_fifo #(.WIDTH(DW), .DEPTH(`ASPRF_FIFO_DEPTH), .AW(3)) u_fifo (
        .i_clk       (i_clk),
        .i_resetn    (i_resetn),
        .i_in_valid  (i_conv_valid),
        .o_in_ready  (o_conv_ready),
        .i_in_data   (i_conv_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (take),
        .o_out_data  (fifo_data)
    );

    always @* begin
        case (sel_reg)
            `ASPRF_REG_MODE, `ASPRF_REG_CTRL, `ASPRF_REG_FILTER: len_next = 5'h08;
            `ASPRF_REG_STATUS: len_next = 5'h08;
            default: len_next = DW[4:0];
        endcase
    end

    always @* begin
        case (sel_reg)
            `ASPRF_REG_STATUS: rd_word = {{(DW-8){1'b0}}, ~o_rdy_n, cal_hold_reg, 6'h00};
            `ASPRF_REG_MODE:   rd_word = {o_mode, {(DW-8){1'b0}}};
            `ASPRF_REG_CTRL:   rd_word = {o_ctrl, {(DW-8){1'b0}}};
            `ASPRF_REG_FILTER: rd_word = {o_filter, {(DW-8){1'b0}}};
            `ASPRF_REG_DATA:   rd_word = data_reg;
            `ASPRF_REG_OFFSET: rd_word = o_offset;
            `ASPRF_REG_GAIN:   rd_word = o_gain;
            default:           rd_word = {DW{1'b0}};
        endcase
        if (sel_reg == `ASPRF_REG_STATUS) begin
            rd_word = {rd_word[7:0], {(DW-8){1'b0}}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. Select and clock reset to their idle high level so
    // that leaving reset never shows a false edge.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cs_sync_reg   <= 2'h3;
            sclk_sync_reg <= 3'h7;
            din_sync_reg  <= 2'h0;
        end else begin
            cs_sync_reg   <= {cs_sync_reg[0], i_cs_n};
            sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
            din_sync_reg  <= {din_sync_reg[0], i_din};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Asynchronous reset restores power-on state of every register.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_reg     <= ST_COMM;
            bits_reg      <= 5'h00;
            in_sh_reg     <= {DW{1'b0}};
            out_sh_reg    <= {DW{1'b0}};
            sel_reg       <= 4'h0;
            data_reg      <= {DW{1'b0}};
            unread_reg    <= 1'b0;
            o_dout        <= 1'b1;
            o_mode        <= `ASPRF_RST_MODE;
            o_mode_wr     <= 1'b0;
            o_ctrl        <= `ASPRF_RST_CTRL;
            o_filter      <= `ASPRF_RST_FILTER;
            o_offset      <= `ASPRF_RST_OFFSET;
            o_gain        <= `ASPRF_RST_GAIN;
        end else begin
            o_mode_wr     <= 1'b0;
            // Bit count and shift state persist across idle clock gaps.
            if (!sel_active) begin
                state_reg <= ST_COMM;
                bits_reg  <= 5'h00;
            end else if (rise && state_reg != ST_RD) begin
                in_sh_reg <= in_word;
                bits_reg  <= bits_reg + 5'h01;
                if (state_reg == ST_COMM && bits_reg == 5'h07) begin
                    bits_reg <= 5'h00;
                    sel_reg  <= in_word[`ASPRF_COMM_RSEL_HI:`ASPRF_COMM_RSEL_LO];
                    if (in_word[`ASPRF_COMM_WR_BIT] == 1'b0) begin
                        state_reg <= ST_RD;
                    end else begin
                        state_reg <= ST_WR;
                    end
                end else if (state_reg == ST_WR && bits_reg == len_next - 5'h01) begin
                    state_reg <= ST_COMM;
                    bits_reg  <= 5'h00;
                    case (sel_reg)
                        `ASPRF_REG_MODE: begin
                            o_mode    <= in_word[7:0];
                            o_mode_wr <= 1'b1;
                        end
                        `ASPRF_REG_CTRL:   o_ctrl   <= in_word[7:0];
                        `ASPRF_REG_FILTER: o_filter <= in_word[7:0];
                        `ASPRF_REG_OFFSET: o_offset <= in_word;
                        `ASPRF_REG_GAIN:   o_gain   <= in_word;
                        default: ;
                    endcase
                end
            end else if (state_reg == ST_RD && fall) begin
                // Data leaves MSB first on the falling edge.
                if (bits_reg == 5'h00) begin
                    o_dout     <= rd_word[DW-1];
                    out_sh_reg <= {rd_word[DW-2:0], 1'b0};
                end else begin
                    o_dout     <= out_sh_reg[DW-1];
                    out_sh_reg <= {out_sh_reg[DW-2:0], 1'b0};
                end
            end else if (state_reg == ST_RD && rise) begin
                bits_reg <= bits_reg + 5'h01;
                if (bits_reg == len_next - 5'h01) begin
                    state_reg <= ST_COMM;
                    bits_reg  <= 5'h00;
                    if (sel_reg == `ASPRF_REG_DATA) begin
                        unread_reg <= 1'b0;
                    end
                end
            end
            if (take) begin
                data_reg   <= fifo_data;
                unread_reg <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Ready flag and calibration hold.
    always @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cal_hold_reg <= 1'b0;
            o_rdy_n      <= 1'b1;
        end else begin
            // Mode write releases the calibration hold; a finish that lands
            // in the same cycle wins so the completion is not lost.
            if (o_mode_wr) begin
                cal_hold_reg <= 1'b0;
            end
            if (i_cal_done) begin
                cal_hold_reg <= 1'b1;
            end
            // Pending result pulls ready high one cycle before the update.
            o_rdy_n <= ~((unread_reg & ~fifo_valid) | cal_hold_reg);
        end
    end
endmodule

/* File: sim/asprf_props_properties.sv */
// Checker for the pin timing, register reset values and ready flag.
module asprf_props #(
    parameter DW = 24
) (
    input wire          i_clk,
    input wire          i_resetn,
    input wire          i_cs_n,
    input wire          i_sclk,
    input wire          i_cal_done,
    input wire          o_dout,
    input wire          o_rdy_n,
    input wire [7:0]    o_mode,
    input wire          o_mode_wr,
    input wire [7:0]    o_ctrl,
    input wire [7:0]    o_filter,
    input wire [DW-1:0] o_offset,
    input wire [DW-1:0] o_gain
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////
    AST_RST_VAL: assert property ($rose(i_resetn) |-> o_ctrl == 8'h07 &&
        o_filter == 8'h45 && o_mode == 8'h00 && o_rdy_n && o_dout)
        else $error("Register or pin left its reset value.");
    AST_CS_CFG: assert property (i_cs_n [*8] |=> $stable(o_ctrl) &&
        $stable(o_offset) && $stable(o_gain) && $stable(o_filter))
        else $error("Register written while select is high.");
    AST_CS_DOUT: assert property (i_cs_n [*8] |=> $stable(o_dout))
        else $error("Serial output moved while select is high.");
    AST_DOUT_FALL: assert property ($changed(o_dout) |-> !$past(i_sclk, 2) ||
        !$past(i_sclk, 3) || !$past(i_sclk, 4) || $past(i_cs_n, 2) || $past(i_cs_n, 3))
        else $error("Serial output moved without a clock fall.");
    AST_MODE_PULSE: assert property (o_mode_wr |=> !o_mode_wr)
        else $error("Mode write strobe longer than one cycle.");
    AST_MODE_STROBE: assert property ($changed(o_mode) |-> ##[0:1] o_mode_wr)
        else $error("Mode changed without its strobe.");
    AST_CAL_LOW: assert property (i_cal_done |-> ##[1:3] !o_rdy_n)
        else $error("Ready not low after calibration.");
    AST_CAL_HOLD: assert property (i_cal_done ##1 !o_mode_wr [*8] |-> !o_rdy_n)
        else $error("Ready rose after calibration without a mode write.");
    COV_CAL: cover property (i_cal_done ##[1:3] !o_rdy_n);
    COV_MODE: cover property (o_mode_wr);
    COV_READ: cover property ($fell(o_dout) ##[1:300] $rose(o_rdy_n));
endmodule

bind asprf_serial_port asprf_props #(.DW(DW)) u_props (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_cal_done(i_cal_done), .o_dout(o_dout),
    .o_rdy_n(o_rdy_n), .o_mode(o_mode), .o_mode_wr(o_mode_wr), .o_ctrl(o_ctrl),
    .o_filter(o_filter), .o_offset(o_offset), .o_gain(o_gain));

/* File: sim/asprf_host.sv */
// Host serial port model that frames each transfer with the select line unless sel_n or three_wire is set.
module asprf_host (
    input  wire  i_clk,
    input  wire  i_dout,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    timeunit 1ns;
    timeprecision 1ns;
    logic three_wire = 1'b0;
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_din  = 1'b1;
    end
    ////////////////////////////////////////
    task automatic phase();
        repeat (4) @(posedge i_clk);
        #2;
    endtask
    // With sel_n high and three_wire clear the clocks run unselected, which the port must ignore.
    task automatic xfer(input logic [31:0] tx, input int n, input logic sel_n,
                        output logic [31:0] rx);
        rx = '0;
        o_cs_n = sel_n & ~three_wire;
        phase();
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_din = tx[i];
            phase();
            o_sclk = 1'b1;
            rx[i] = i_dout;
            phase();
        end
        o_din = ~o_din;
        if (!three_wire) o_cs_n = 1'b1;
        phase();
    endtask
endmodule

/* File: sim/adc_serial_port_ready_flag_test.sv */
// Self-checking bench for the converter serial port and ready flag.
module adc_serial_port_ready_flag_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clk = 1'b0, i_resetn = 1'b0, i_conv_valid = 1'b0, i_cal_done = 1'b0;
    logic [23:0] i_conv_data = '0;
    logic [31:0] rx;
    wire         cs_n, sclk, din, dout, rdy_n, conv_ready, mode_wr;
    wire  [7:0]  mode, ctrl, filt;
    wire  [23:0] offs, gain;
    int          error_cnt = 0, checks_done = 0;
    initial forever #25 i_clk = ~i_clk;
    asprf_host host (.i_clk(i_clk), .i_dout(dout), .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));
    asprf_serial_port #(.DW(24)) dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_cs_n(cs_n),
        .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_rdy_n(rdy_n), .i_conv_valid(i_conv_valid),
        .o_conv_ready(conv_ready), .i_conv_data(i_conv_data), .i_cal_done(i_cal_done),
        .o_mode(mode), .o_mode_wr(mode_wr), .o_ctrl(ctrl), .o_filter(filt), .o_offset(offs),
        .o_gain(gain));
    ////////////////////////////////////////
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #2;
    endtask
    task automatic wait_low();
        for (int i = 0; i < 60 && rdy_n !== 1'b0; i++) cyc(1);
    endtask
    task automatic push(input logic [23:0] d);
        i_conv_data = d;
        i_conv_valid = 1'b1;
        cyc(1);
        i_conv_valid = 1'b0;
    endtask
    task automatic wr(input logic [3:0] sel, input int w, input logic [23:0] v);
        host.xfer(({24'h0, 4'h8, sel} << w) | v, 8 + w, 1'b0, rx);
        cyc(4);
    endtask
    task automatic t_reset();
        chk(ctrl === 8'h07 && filt === 8'h45 && mode === 8'h00, "reset values");
        chk(offs === 24'h800000 && gain === 24'h500000 && rdy_n === 1'b1, "reset cal");
    endtask
    task automatic t_write();
        wr(4'h2, 8, 24'hA5);
        wr(4'h3, 8, 24'h5A);
        wr(4'h5, 24, 24'h123456);
        wr(4'h6, 24, 24'hABCDEF);
        wr(4'h7, 8, 24'hFF);
        chk(ctrl === 8'hA5 && filt === 8'h5A, "control write");
        chk(offs === 24'h123456 && gain === 24'hABCDEF, "calibration write");
        host.xfer({16'h0, 8'h02, 8'h00}, 16, 1'b0, rx);
        chk(rx[7:0] === 8'hA5, "control readback");
        host.xfer({8'h06, 24'h0}, 32, 1'b0, rx);
        chk(rx[23:0] === 24'hABCDEF, "gain readback");
        host.xfer({16'h0, 8'h03, 8'h00}, 16, 1'b0, rx);
        chk(rx[7:0] === 8'h5A, "filter readback");
        host.xfer({16'h0, 8'h82, 8'h3C}, 16, 1'b1, rx);
        chk(ctrl === 8'hA5, "unselected write");
    endtask
    task automatic t_data(input logic [23:0] d);
        wait_low();
        chk(rdy_n === 1'b0, "ready low");
        host.xfer({8'h04, 24'h0}, 32, 1'b0, rx);
        chk(rx[23:0] === d, "data read");
        chk(rdy_n === 1'b1, "ready high after read");
    endtask
    task automatic t_newer();
        logic seen;
        seen = 1'b0;
        push(24'h13579B);
        wait_low();
        push(24'h2468AC);
        for (int i = 0; i < 6; i++) begin
            seen |= rdy_n;
            cyc(1);
        end
        chk(seen === 1'b1, "ready rises before update");
        t_data(24'h2468AC);
    endtask
    task automatic t_fill();
        int acc;
        acc = 0;
        push(24'h0000C3);
        wait_low();
        fork
            host.xfer({8'h04, 24'h0}, 32, 1'b0, rx);
            begin
                cyc(80);
                for (int k = 0; k < 12; k++) begin
                    i_conv_data = 24'hF00000 + acc;
                    i_conv_valid = 1'b1;
                    if (conv_ready === 1'b1) acc++;
                    @(posedge i_clk);
                    #2;
                end
                i_conv_valid = 1'b0;
            end
        join
        chk(rx[23:0] === 24'h0000C3 && acc == 8, "buffer fill");
        t_data(24'hF00007);
    endtask
    task automatic t_cal();
        i_cal_done = 1'b1;
        cyc(1);
        i_cal_done = 1'b0;
        cyc(3);
        chk(rdy_n === 1'b0, "ready low after calibration");
        cyc(30);
        chk(rdy_n === 1'b0, "ready held after calibration");
        host.xfer({16'h0, 8'h00, 8'h00}, 16, 1'b0, rx);
        chk(rx[7:0] === 8'hC0 && rdy_n === 1'b0, "status during hold");
        wr(4'h1, 8, 24'h03);
        chk(mode === 8'h03 && rdy_n === 1'b1, "mode write releases ready");
    endtask
    task automatic t_three();
        host.three_wire = 1'b1;
        host.xfer(32'h82, 8, 1'b0, rx);
        cyc(20);
        host.xfer(32'h66, 8, 1'b0, rx);
        cyc(4);
        chk(ctrl === 8'h66, "three-wire write");
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // The watchdog allows several times the expected run before giving up.
    initial begin
        #2000000;
        error_cnt++;
        tally_and_finish();
    end
    initial begin
        cyc(12);
        i_resetn = 1'b1;
        cyc(4);
        t_reset();
        t_write();
        push(24'h5A5A5A);
        t_data(24'h5A5A5A);
        t_newer();
        t_fill();
        t_cal();
        t_three();
        i_resetn = 1'b0;
        cyc(2);
        i_resetn = 1'b1;
        cyc(2);
        t_reset();
        tally_and_finish();
    end
endmodule
